// ===== inc/twm_params.svh
// Purpose: constants of the two-wire master transmitter
// Assumes: 100 MHz system clock
// Notes: status codes carry the low three bits as zero
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH
`define TWM_OFS_CTRL 4'h0
`define TWM_OFS_STAT 4'h4
`define TWM_OFS_DATA 4'h8
`define TWM_OFS_MODE 4'hc
`define TWM_CLK_NS 10
`define TWM_HALF_NS 5000
`define TWM_FREE_NS 4700
`define TWM_NS2CYC(ns) (((ns) + `TWM_CLK_NS - 1) / `TWM_CLK_NS)
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_LOST 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_IDLE 8'hf8
`define TWM_CTRL_RST 8'h00
`define TWM_DATA_RST 8'h00
`define TWM_PRESC_RST 2'h0
`endif

// ===== inc/twm_pkg.sv
// Purpose: types of the two-wire master transmitter
// Assumes: nothing
// Notes: control layout is the bus_control_register bit order
package twm_pkg;
  typedef struct packed {
    logic flag;
    logic ack_en;
    logic start;
    logic stop;
    logic wcol;
    logic enable;
    logic rsvd;
    logic irq_en;
  } twm_ctrl_type;
  typedef struct packed {
    logic scl;
    logic sda;
  } twm_drive_type;
  typedef enum logic [3:0] {
    S_IDLE, S_FREE, S_STA1, S_STA2, S_SUSP, S_BLO, S_BHI, S_ALO,
    S_AHI, S_STO1, S_STO2, S_STO3, S_RS1, S_RS2, S_LOST
  } twm_state_type;
endpackage : twm_pkg

// ===== hdl/twm_master.sv
// Purpose: two-wire master transmitter with a classic Wishbone register slave
// Assumes: open-drain pins resolved outside; scl and sda arrive asynchronously
// Notes: receive mode reports entry only; there a clear serves stop or restart
// Overview of operation
// - Unit works only while enable is set
// - Start only after bus seen free
// - After start: flag set, status 0x08
// - Address write bit selects transmit, read receive
// - Transfer held while flag set; one clears
// - After write address: flag, status 18/20/38
// - Data write with flag low: dropped, collision
// - Stop request sent, then stop bit cleared
// - Repeated start reports 0x10, keeps the bus
// - At 0x08 address sent, acknowledge sampled
// - At 0x10 read address enters receive mode
// - At 0x18 start/stop bits choose next action
// - Not acknowledged address still permits data
// - Read high, write low, ack low, 8 bits
// - Lost arbitration: 0x38, release or queue start
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "twm_params.svh"
module twm_master
  import twm_pkg::*;
#(
  parameter int HALF_CYCLES = `TWM_NS2CYC(`TWM_HALF_NS),
  parameter int FREE_CYCLES = `TWM_NS2CYC(`TWM_FREE_NS)
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial lines, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Processor interrupt
  output logic irq
);
  localparam logic [15:0] HALF = 16'(HALF_CYCLES);
  localparam logic [15:0] FREE = 16'(FREE_CYCLES);

  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic busy, next_busy;
  logic next_ack;
  logic [31:0] next_rdat;
  logic wr_go;
  twm_state_type state, next_state;
  logic [15:0] cnt, next_cnt;
  twm_ctrl_type ctrl, next_ctrl;
  logic [7:0] status, next_status;
  logic [1:0] presc, next_presc;
  logic [7:0] data, next_data;
  logic [7:0] shreg, next_shreg;
  logic [2:0] bitcnt, next_bitcnt;
  logic is_addr, next_is_addr;
  logic rw, next_rw;
  logic mr, next_mr;
  logic rs, next_rs;
  twm_drive_type drv, next_drv;
  logic flag_set, hi_phase, done, mastering;
  twm_ctrl_type wr_ctrl;

  // Pins are asynchronous: two flops before use
  always_ff @(posedge clk)
  begin
    scl_m <= scl_i;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= sda_i;
    sda_s <= sda_m;
    sda_d <= sda_s;
  end

  // Bus busy from start and stop seen on the lines
  always_comb
  begin
    next_busy = busy;
    if (scl_s && scl_d && sda_d && !sda_s)
      next_busy = 1'b1;
    if (scl_s && scl_d && !sda_d && sda_s)
      next_busy = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      busy <= 1'b0;
    else
      busy <= next_busy;
  end

  // Wishbone: ack one cycle after the request; writes land at the ack edge
  assign mastering = (state != S_IDLE) && (state != S_FREE) && (state != S_LOST);
  always_comb
  begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_rdat = 32'h0;
    unique case (wb_adr_i)
      `TWM_OFS_CTRL: next_rdat = {24'h0, ctrl};
      `TWM_OFS_STAT: next_rdat = {24'h0, status[7:3], 1'b0, presc};
      `TWM_OFS_DATA: next_rdat = {24'h0, data};
      `TWM_OFS_MODE: next_rdat = {30'h0, mastering && mr, mastering && !mr};
      default: next_rdat = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
    end
  end

  assign wr_go = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign wr_ctrl = wb_dat_i[7:0];
  assign hi_phase = (state == S_BHI) || (state == S_AHI) || (state == S_STO2) || (state == S_RS2);
  assign done = (cnt == 16'h0);

  // Transfer engine and register file
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_ctrl = ctrl;
    next_status = status;
    next_presc = presc;
    next_data = data;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_is_addr = is_addr;
    next_rw = rw;
    next_mr = mr;
    next_rs = rs;
    next_drv = drv;
    flag_set = 1'b0;
    // Slave may stretch the high phase by holding scl low
    if (!done && !(hi_phase && !scl_s))
      next_cnt = cnt - 16'h1;
    unique case (state)
      S_IDLE:
      begin
        next_drv = '0;
        if (ctrl.enable && !ctrl.flag && ctrl.start)
        begin
          next_state = S_FREE;
          next_cnt = FREE;
        end
      end
      S_FREE:
      begin
        next_rs = 1'b0;
        if (!(scl_s && sda_s) || busy)
          next_cnt = FREE;
        else if (done)
        begin
          next_state = S_STA1;
          next_drv.sda = 1'b1;
          next_cnt = HALF;
        end
      end
      S_STA1:
        if (done)
        begin
          next_state = S_STA2;
          next_drv.scl = 1'b1;
          next_cnt = HALF;
        end
      S_STA2:
        if (done)
        begin
          next_state = S_SUSP;
          flag_set = 1'b1;
          next_is_addr = 1'b1;
          next_status = rs ? `TWM_ST_RSTART : `TWM_ST_START;
        end
      S_SUSP:
        if (!ctrl.flag)
        begin
          if (ctrl.stop)
          begin
            next_state = S_STO1;
            next_drv.sda = 1'b1;
            next_cnt = HALF;
          end
          else if (ctrl.start)
          begin
            next_state = S_RS1;
            next_drv.sda = 1'b0;
            next_cnt = HALF;
          end
          else if (!mr)
          begin
            next_state = S_BLO;
            next_shreg = data;
            next_bitcnt = 3'h0;
            next_drv.sda = !data[7];
            next_cnt = HALF;
            if (is_addr)
              next_rw = data[0];
          end
        end
      S_BLO:
        if (done)
        begin
          next_state = S_BHI;
          next_drv.scl = 1'b0;
          next_cnt = HALF;
        end
      S_BHI:
        if (scl_s && !drv.sda && !sda_s)
        begin
          next_state = S_LOST;
          next_drv = '0;
          flag_set = 1'b1;
          next_status = `TWM_ST_LOST;
          next_mr = 1'b0;
        end
        else if (done)
        begin
          next_shreg = {shreg[6:0], 1'b0};
          next_bitcnt = bitcnt + 3'h1;
          next_drv.scl = 1'b1;
          next_cnt = HALF;
          if (bitcnt == 3'h7)
          begin
            next_state = S_ALO;
            next_drv.sda = 1'b0;
          end
          else
          begin
            next_state = S_BLO;
            next_drv.sda = !shreg[6];
          end
        end
      S_ALO:
        if (done)
        begin
          next_state = S_AHI;
          next_drv.scl = 1'b0;
          next_cnt = HALF;
        end
      S_AHI:
        if (done)
        begin
          next_state = S_SUSP;
          next_drv.scl = 1'b1;
          flag_set = 1'b1;
          next_is_addr = 1'b0;
          if (is_addr && rw)
          begin
            next_mr = 1'b1;
            next_status = sda_s ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
          end
          else if (is_addr)
            next_status = sda_s ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
          else
            next_status = sda_s ? `TWM_ST_D_NACK : `TWM_ST_D_ACK;
        end
      S_STO1:
        if (done)
        begin
          next_state = S_STO2;
          next_drv.scl = 1'b0;
          next_cnt = HALF;
        end
      S_STO2:
        if (done)
        begin
          next_state = S_STO3;
          next_drv.sda = 1'b0;
          next_cnt = HALF;
        end
      S_STO3:
        if (done)
        begin
          next_ctrl.stop = 1'b0;
          next_status = `TWM_ST_IDLE;
          next_mr = 1'b0;
          next_state = ctrl.start ? S_FREE : S_IDLE;
          next_cnt = FREE;
        end
      S_RS1:
        if (done)
        begin
          next_state = S_RS2;
          next_drv.scl = 1'b0;
          next_cnt = HALF;
        end
      S_RS2:
        if (done)
        begin
          next_state = S_STA1;
          next_drv.sda = 1'b1;
          next_rs = 1'b1;
          next_mr = 1'b0;
          next_cnt = HALF;
        end
      S_LOST:
        if (!ctrl.flag)
        begin
          next_state = ctrl.start ? S_FREE : S_IDLE;
          next_cnt = FREE;
        end
      default: next_state = S_IDLE;
    endcase
    // Software writes; a stop request written now beats the hardware clear
    if (wr_go)
    begin
      unique case (wb_adr_i)
        `TWM_OFS_CTRL:
        begin
          next_ctrl.ack_en = wr_ctrl.ack_en;
          next_ctrl.start = wr_ctrl.start;
          next_ctrl.stop = wr_ctrl.stop;
          next_ctrl.enable = wr_ctrl.enable;
          next_ctrl.irq_en = wr_ctrl.irq_en;
          if (wr_ctrl.flag)
            next_ctrl.flag = 1'b0;
        end
        `TWM_OFS_STAT: next_presc = wb_dat_i[1:0];
        `TWM_OFS_DATA:
          if (ctrl.flag)
          begin
            next_data = wb_dat_i[7:0];
            next_ctrl.wcol = 1'b0;
          end
          else
            next_ctrl.wcol = 1'b1;
        default: next_data = data;
      endcase
    end
    // Hardware set of the flag wins over a clear in the same cycle
    if (flag_set)
      next_ctrl.flag = 1'b1;
    if (!ctrl.enable)
    begin
      next_state = S_IDLE;
      next_drv = '0;
      next_mr = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= S_IDLE;
      cnt <= 16'h0;
      ctrl <= `TWM_CTRL_RST;
      status <= `TWM_ST_IDLE;
      presc <= `TWM_PRESC_RST;
      data <= `TWM_DATA_RST;
      shreg <= 8'h0;
      bitcnt <= 3'h0;
      is_addr <= 1'b0;
      rw <= 1'b0;
      mr <= 1'b0;
      rs <= 1'b0;
      drv <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      ctrl <= next_ctrl;
      status <= next_status;
      presc <= next_presc;
      data <= next_data;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      is_addr <= next_is_addr;
      rw <= next_rw;
      mr <= next_mr;
      rs <= next_rs;
      drv <= next_drv;
    end
  end

  // Lines only ever pulled low; release leaves them to the pull-up
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = !drv.scl;
  assign sda_oe_n = !drv.sda;
  assign irq = ctrl.flag && ctrl.irq_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  start_status_a: assert property ($past(state) == S_STA2 && state == S_SUSP && !rs
    |-> ctrl.flag && status == `TWM_ST_START)
    else $error("start did not report 0x08");
  rstart_status_a: assert property ($past(state) == S_STA2 && state == S_SUSP && rs
    |-> status == `TWM_ST_RSTART)
    else $error("repeated start did not report 0x10");
  free_bus_a: assert property ($past(state) == S_FREE && state == S_STA1 |-> $past(scl_s && sda_s && !busy, 2))
    else $error("start issued on a busy bus");
  suspend_hold_a: assert property (state == S_SUSP && ctrl.flag && ctrl.enable |=> state == S_SUSP)
    else $error("transfer moved while flag set");
  collision_a: assert property (wr_go && wb_adr_i == `TWM_OFS_DATA && !ctrl.flag
    |=> ctrl.wcol && data == $past(data))
    else $error("collision write not discarded");
  stop_clear_a: assert property (state == S_STO3 && done && !wr_go && ctrl.enable |=> !ctrl.stop)
    else $error("stop bit not cleared after stop");
  addr_write_a: assert property ($past(state) == S_AHI && state == S_SUSP && $past(is_addr && !rw)
    |-> status == `TWM_ST_AW_ACK || status == `TWM_ST_AW_NACK)
    else $error("bad status after write address");
  write_bit_a: assert property (state == S_BHI && bitcnt == 3'h7 && is_addr && !rw |-> !sda_oe_n)
    else $error("write bit not driven low");
  arb_lost_a: assert property (state == S_BHI && scl_s && !drv.sda && !sda_s && ctrl.enable
    |=> state == S_LOST && status == `TWM_ST_LOST ##1 scl_oe_n && sda_oe_n)
    else $error("arbitration loss not handled");
  disable_release_a: assert property (!ctrl.enable |=> ##1 scl_oe_n && sda_oe_n)
    else $error("lines held while disabled");
  irq_raise_a: assert property ($rose(ctrl.flag) && ctrl.irq_en |-> irq)
    else $error("interrupt not raised");

  start_sent_c: cover property (state == S_STA2 && done);
  data_sent_c: cover property (state == S_AHI && done && !is_addr);
  stop_sent_c: cover property (state == S_STO3 && done);
  lost_c: cover property (state == S_LOST);
endmodule : twm_master

// ===== tb/twm_slave_model.sv
// Purpose: serial receiver on the far side of the two-wire master
// Assumes: both lines pulled up; this receiver never stretches the clock
// Notes: acks its own address and every byte after it, nacks all else
`timescale 1ns/10ps
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Data pull, low pulls sda
  output logic sda_n,
  // Last data byte taken
  output logic [7:0] last_byte
);
  logic [7:0] shift;
  int cnt;
  logic first;
  logic sel;
  initial
  begin
    sda_n = 1'b1;
    cnt = 0;
    first = 1'b0;
    sel = 1'b0;
    last_byte = 8'h00;
    shift = 8'h00;
  end
  // Start or repeated start restarts the byte count
  always @(negedge sda)
    if (scl)
    begin
      cnt = 0;
      first = 1'b1;
      sda_n = 1'b1;
    end
  always @(posedge sda)
    if (scl)
      sel = 1'b0;
  // Bits taken on the rising clock, first bit is the top one
  always @(posedge scl)
    if (cnt < 8)
    begin
      shift = {shift[6:0], sda};
      cnt = cnt + 1;
    end
  // Ack low only while selected; released on the next low phase
  always @(negedge scl)
    if (cnt == 8)
    begin
      if (first)
        sel = (shift[7:1] == ADDR);
      else if (sel)
        last_byte = shift;
      sda_n = ~sel;
      first = 1'b0;
      cnt = 9;
    end
    else if (cnt == 9)
    begin
      sda_n = 1'b1;
      cnt = 0;
    end
endmodule : twm_slave_model

// ===== tb/tb_top.sv
// Purpose: register-level test of the two-wire master transmitter
// Assumes: short serial phases so a whole transfer takes a few hundred cycles
// Notes: flag is polled over the register bus, as software would
`timescale 1ns/10ps
module tb_top
  import twm_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic arb_n = 1'b1;
  logic scl_dr, sda_dr;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic ack, scl_oe_n, sda_oe_n, irq, sl_n, scl_w, sda_w;
  logic [7:0] q, seen;
  int fail_count = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  // Both lines pulled up; low while any party pulls
  // A second master seizing sda is modelled by arb_n
  assign scl_w = scl_oe_n | scl_dr;
  assign sda_w = (sda_oe_n | sda_dr) & sl_n & arb_n;
  twm_master #(.HALF_CYCLES(6), .FREE_CYCLES(4)) dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .scl_i(scl_w), .scl_o(scl_dr), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_dr),
    .sda_oe_n(sda_oe_n), .irq(irq));
  twm_slave_model #(.ADDR(7'h50)) slave (.scl(scl_w), .sda(sda_w), .sda_n(sl_n), .last_byte(seen));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; ack sampled and data taken at the same rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rd[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : wb
  // Control write, then poll until suspended and check the code
  task automatic step(input logic [7:0] c, input logic [7:0] code);
    wb(1'b1, 4'h0, c);
    q = 8'h00;
    while (q[7] !== 1'b1) wb(1'b0, 4'h0, 8'h00);
    chk({7'h0, scl_w}, 8'h00);
    wb(1'b0, 4'h4, 8'h00);
    chk(q & 8'hf8, code);
  endtask : step
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Whole run needs well under this
  initial
  begin
    #300000;
    fail_count++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wb(1'b0, 4'h0, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, 4'h4, 8'h00);
    chk(q, 8'hf8);
    wb(1'b0, 4'h2, 8'h00);
    chk(q, 8'h00);
    wb(1'b1, 4'h4, 8'h03);
    wb(1'b0, 4'h4, 8'h00);
    chk(q, 8'hfb);
    wb(1'b1, 4'h8, 8'h55);
    wb(1'b0, 4'h0, 8'h00);
    chk(q, 8'h08);
    wb(1'b0, 4'h8, 8'h00);
    chk(q, 8'h00);
    step(8'ha5, 8'h08);
    chk({7'h0, irq}, 8'h01);
    wb(1'b1, 4'h8, 8'ha0);
    wb(1'b0, 4'h0, 8'h00);
    chk(q & 8'h08, 8'h00);
    step(8'h85, 8'h18);
    wb(1'b0, 4'hc, 8'h00);
    chk(q, 8'h01);
    step(8'ha5, 8'h10);
    wb(1'b1, 4'h8, 8'ha0);
    step(8'h85, 8'h18);
    wb(1'b1, 4'h8, 8'h3c);
    step(8'h85, 8'h28);
    chk(seen, 8'h3c);
    step(8'ha5, 8'h10);
    wb(1'b1, 4'h8, 8'h84);
    step(8'h85, 8'h20);
    wb(1'b1, 4'h8, 8'hc3);
    step(8'h85, 8'h30);
    step(8'hb5, 8'h08);
    wb(1'b1, 4'h8, 8'ha1);
    step(8'h85, 8'h40);
    wb(1'b0, 4'hc, 8'h00);
    chk(q, 8'h02);
    wb(1'b1, 4'h0, 8'h95);
    q = 8'h10;
    while (q[4] !== 1'b0) wb(1'b0, 4'h0, 8'h00);
    chk({6'h0, scl_w, sda_w}, 8'h03);
    wb(1'b0, 4'h4, 8'h00);
    chk(q, 8'hfb);
    chk({7'h0, irq}, 8'h00);
    // Lost arbitration: the other master holds sda low through the first bit
    step(8'ha5, 8'h08);
    wb(1'b1, 4'h8, 8'hff);
    arb_n <= 1'b0;
    wb(1'b1, 4'h0, 8'h85);
    q = 8'h00;
    while (q[7] !== 1'b1) wb(1'b0, 4'h0, 8'h00);
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    arb_n <= 1'b1;
    wb(1'b0, 4'h4, 8'h00);
    chk(q & 8'hf8, 8'h38);
    step(8'ha5, 8'h08);
    give_verdict();
  end
endmodule : tb_top
